// ### design/glch_defs.vh
`ifndef GLCH_DEFS_VH
`define GLCH_DEFS_VH

// register byte offsets
`define GLCH_OFF_CTRL      8'h00
`define GLCH_OFF_CMD       8'h04
`define GLCH_OFF_ARG0      8'h08
`define GLCH_OFF_ARG1      8'h0c
`define GLCH_OFF_ARG2      8'h10
`define GLCH_OFF_RESP      8'h14
`define GLCH_OFF_STAT      8'h18
`define GLCH_OFF_MASK      8'h1c
`define GLCH_OFF_PINS      8'h20

// field positions
`define GLCH_CTRL_ACK_BIT  0
`define GLCH_STAT_DONE_BIT 0
`define GLCH_STAT_ERR_BIT  1
`define GLCH_RESP_VLD_BIT  16
`define GLCH_RESP_FLD_BIT  17

// reset values
`define GLCH_CTRL_RST      1'b1
`define GLCH_MASK_RST      2'b00

// command opcodes, written to CMD[2:0]
`define GLCH_OP_LEDCFG     3'h1
`define GLCH_OP_GPIOCFG    3'h2
`define GLCH_OP_WRITE      3'h3
`define GLCH_OP_READ       3'h4
`define GLCH_OP_TOGGLE     3'h5

// argument lengths in bytes
`define GLCH_LEN_LEDCFG    4'ha
`define GLCH_LEN_GPIOCFG   4'h2
`define GLCH_LEN_WRITE     4'h2
`define GLCH_LEN_READ      4'h1
`define GLCH_LEN_TOGGLE    4'h1

// response codes
`define GLCH_RC_OK         8'h00
`define GLCH_RC_SHORT      8'h01
`define GLCH_RC_LONG       8'h02
`define GLCH_RC_NOTGPIO    8'h08
`define GLCH_RC_INUSE      8'h09
`define GLCH_RC_BADCFG     8'h12
`define GLCH_RC_NOTOUT     8'h16
`define GLCH_RC_UNCFG      8'h17

// pin configuration byte layout
`define GLCH_CFG_DIR_BIT   0
`define GLCH_CFG_LVL_BIT   1
`define GLCH_CFG_IGN_MASK  8'h04
`define GLCH_CFG_RSV_MASK  8'hf8

// pin modes
`define GLCH_MODE_UNUSED   2'h0
`define GLCH_MODE_GIN      2'h1
`define GLCH_MODE_GOUT     2'h2
`define GLCH_MODE_LED      2'h3

// indicator pulse length
`define GLCH_CLK_NS        4
`define GLCH_LED_PULSE_NS  10000000
`define GLCH_LED_PULSE_CYC (`GLCH_LED_PULSE_NS / `GLCH_CLK_NS)

`endif

// ### design/glch_top.v
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "glch_defs.vh"
`default_nettype none

module glch_pulse #(
	parameter integer CYC = 2500000
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        trig,
	output wire        active
);
	reg [23:0] cnt_r;

	// retriggerable: each new event restarts the full pulse
	always @(posedge aclk) begin
		if (!aresetn)
			cnt_r <= 24'h000000;
		else if (trig)
			cnt_r <= CYC[23:0];
		else if (cnt_r != 24'h000000)
			cnt_r <= cnt_r - 24'h000001;
	end

	assign active = (cnt_r != 24'h000000);
endmodule // glch_pulse

module glch_top #(
	parameter integer LED_PULSE_CYC = `GLCH_LED_PULSE_CYC,
	parameter [15:0]  GPIO_CAP      = 16'hffff,
	parameter [15:0]  LED_CAP       = 16'hffff
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        net_rx_evt,
	input  wire        net_tx_evt,
	input  wire        ser_rx_evt,
	input  wire        ser_tx_evt,
	input  wire        awake,
	input  wire [15:0] iface_use,
	input  wire [15:0] wake_use,
	input  wire [15:0] pin_in,
	output reg  [15:0] pin_out,
	output reg  [15:0] pin_oe_n,
	output wire        irq
);
	localparam integer NLED = 5;

	reg         ack_en_r;
	reg  [1:0]  mask_r;
	reg  [1:0]  stat_r;
	reg  [95:0] args_r;
	reg  [2:0]  op_r;
	reg  [3:0]  len_r;
	reg         go_r;
	reg  [17:0] resp_r;
	reg  [31:0] mode_r;
	reg  [15:0] lvl_r;
	reg  [39:0] led_pin_r;
	reg  [4:0]  led_inv_r;
	reg  [15:0] in_meta_r;
	reg  [15:0] in_sync_r;

	// register bus
	wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire [7:0]  waddr = {s_axi_awaddr[7:2], 2'b00};
	wire [7:0]  raddr = {s_axi_araddr[7:2], 2'b00};
	wire        stat_rd = rd_go & (raddr == `GLCH_OFF_STAT);

	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0]  stb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (stb[b])
					merge[8*b +: 8] = dat[8*b +: 8];
		end
	endfunction

	reg         w_hit;
	always @* begin
		case (waddr)
			`GLCH_OFF_CTRL, `GLCH_OFF_CMD, `GLCH_OFF_ARG0, `GLCH_OFF_ARG1,
			`GLCH_OFF_ARG2, `GLCH_OFF_MASK: w_hit = 1'b1;
			default: w_hit = 1'b0;
		endcase
	end

	// command evaluation
	reg  [31:0] n_mode;
	reg  [15:0] n_lvl;
	reg  [39:0] n_led_pin;
	reg  [4:0]  n_led_inv;
	reg  [7:0]  n_code;
	reg  [7:0]  n_fld;
	reg         n_hasfld;
	reg         n_known;
	reg         err;
	reg  [3:0]  want;
	reg  [7:0]  p;
	reg  [7:0]  c;
	reg  [3:0]  idx;
	reg         p_ok;
	reg  [1:0]  m;
	reg         ext;
	integer     j;

	always @* begin
		n_mode    = mode_r;
		n_lvl     = lvl_r;
		n_led_pin = led_pin_r;
		n_led_inv = led_inv_r;
		n_code    = `GLCH_RC_OK;
		n_fld     = 8'h00;
		n_hasfld  = 1'b0;
		n_known   = 1'b1;
		err       = 1'b0;
		p         = args_r[7:0];
		c         = args_r[15:8];
		idx       = p[3:0] - 4'h1;
		p_ok      = (p != 8'h00) && (p <= 8'h10);
		m         = mode_r[2*idx +: 2];
		ext       = iface_use[idx] | wake_use[idx];
		case (op_r)
			`GLCH_OP_LEDCFG:  want = `GLCH_LEN_LEDCFG;
			`GLCH_OP_GPIOCFG: want = `GLCH_LEN_GPIOCFG;
			`GLCH_OP_WRITE:   want = `GLCH_LEN_WRITE;
			`GLCH_OP_READ:    want = `GLCH_LEN_READ;
			`GLCH_OP_TOGGLE:  want = `GLCH_LEN_TOGGLE;
			default: begin
				want    = 4'h0;
				n_known = 1'b0;
			end
		endcase
		if (n_known && len_r < want) begin
			n_code = `GLCH_RC_SHORT;
		end else if (n_known && len_r > want) begin
			n_code = `GLCH_RC_LONG;
		end else begin
			case (op_r)
				`GLCH_OP_LEDCFG: begin
					// earlier indicator pins are released, so a reassignment may reuse them
					for (j = 0; j < 32; j = j + 2)
						if (n_mode[j +: 2] == `GLCH_MODE_LED)
							n_mode[j +: 2] = `GLCH_MODE_UNUSED;
					n_led_pin = 40'h0;
					for (j = 0; j < NLED; j = j + 1) begin
						p    = args_r[16*j +: 8];
						c    = args_r[16*j+8 +: 8] & ~`GLCH_CFG_IGN_MASK;
						idx  = p[3:0] - 4'h1;
						p_ok = (p != 8'h00) && (p <= 8'h10);
						// pin 0 leaves this indicator off
						if (!err && p != 8'h00) begin
							if (!p_ok || !LED_CAP[idx]) begin
								err      = 1'b1;
								n_code   = `GLCH_RC_NOTGPIO;
								n_fld    = p;
								n_hasfld = 1'b1;
							end else if (n_mode[2*idx +: 2] != `GLCH_MODE_UNUSED ||
								iface_use[idx] || wake_use[idx]) begin
								err      = 1'b1;
								n_code   = `GLCH_RC_INUSE;
								n_fld    = p;
								n_hasfld = 1'b1;
							end else if ((c & `GLCH_CFG_RSV_MASK) != 8'h00 ||
								!c[`GLCH_CFG_DIR_BIT]) begin
								err    = 1'b1;
								n_code = `GLCH_RC_BADCFG;
							end else begin
								n_mode[2*idx +: 2] = `GLCH_MODE_LED;
								n_led_pin[8*j +: 8] = p;
								n_led_inv[j] = c[`GLCH_CFG_LVL_BIT];
							end
						end
					end
					// all five are applied together or none is
					if (err) begin
						n_mode    = mode_r;
						n_led_pin = led_pin_r;
						n_led_inv = led_inv_r;
					end
				end
				`GLCH_OP_GPIOCFG: begin
					if (!p_ok || !GPIO_CAP[idx]) begin
						n_code   = `GLCH_RC_NOTGPIO;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else if (m != `GLCH_MODE_UNUSED || ext) begin
						n_code   = `GLCH_RC_INUSE;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else if ((c & `GLCH_CFG_RSV_MASK) != 8'h00) begin
						n_code = `GLCH_RC_BADCFG;
					end else begin
						n_mode[2*idx +: 2] = c[`GLCH_CFG_DIR_BIT] ?
							`GLCH_MODE_GOUT : `GLCH_MODE_GIN;
						n_lvl[idx] = c[`GLCH_CFG_LVL_BIT];
					end
				end
				`GLCH_OP_WRITE, `GLCH_OP_TOGGLE: begin
					if (!p_ok || !GPIO_CAP[idx]) begin
						n_code   = `GLCH_RC_NOTGPIO;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else if (m != `GLCH_MODE_GOUT) begin
						n_code   = `GLCH_RC_NOTOUT;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else if (op_r == `GLCH_OP_TOGGLE) begin
						n_lvl[idx] = ~lvl_r[idx];
					end else if (c[7:1] != 7'h00) begin
						n_code = `GLCH_RC_BADCFG;
					end else begin
						n_lvl[idx] = c[0];
					end
				end
				`GLCH_OP_READ: begin
					if (!p_ok || (!GPIO_CAP[idx] && !ext && m != `GLCH_MODE_LED)) begin
						n_code   = `GLCH_RC_NOTGPIO;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else if (m == `GLCH_MODE_UNUSED && !ext) begin
						n_code   = `GLCH_RC_UNCFG;
						n_fld    = p;
						n_hasfld = 1'b1;
					end else begin
						n_fld    = {7'h00, in_sync_r[idx]};
						n_hasfld = 1'b1;
					end
				end
				default: begin
					n_code = `GLCH_RC_OK;
				end
			endcase
		end
	end

	// read answers always carry their value; other successes need acks on
	wire send = n_known & ((n_code != `GLCH_RC_OK) | ack_en_r | (op_r == `GLCH_OP_READ));

	// clocked state
	always @(posedge aclk) begin
		if (!aresetn) begin
			ack_en_r     <= `GLCH_CTRL_RST;
			mask_r       <= `GLCH_MASK_RST;
			stat_r       <= 2'b00;
			args_r       <= 96'h0;
			op_r         <= 3'h0;
			len_r        <= 4'h0;
			go_r         <= 1'b0;
			resp_r       <= 18'h0;
			mode_r       <= 32'h0;
			lvl_r        <= 16'h0;
			led_pin_r    <= 40'h0;
			led_inv_r    <= 5'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'b00;
			s_axi_rdata  <= 32'h0;
		end else begin
			go_r <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_hit ? 2'b00 : 2'b10;
				case (waddr)
					`GLCH_OFF_CTRL: if (s_axi_wstrb[0])
						ack_en_r <= s_axi_wdata[`GLCH_CTRL_ACK_BIT];
					`GLCH_OFF_MASK: if (s_axi_wstrb[0])
						mask_r <= s_axi_wdata[1:0];
					`GLCH_OFF_ARG0: args_r[31:0] <= merge(args_r[31:0], s_axi_wdata, s_axi_wstrb);
					`GLCH_OFF_ARG1: args_r[63:32] <= merge(args_r[63:32], s_axi_wdata, s_axi_wstrb);
					`GLCH_OFF_ARG2: args_r[95:64] <= merge(args_r[95:64], s_axi_wdata, s_axi_wstrb);
					`GLCH_OFF_CMD: begin
						op_r  <= s_axi_wdata[2:0];
						len_r <= s_axi_wdata[11:8];
						go_r  <= 1'b1;
					end
					default: begin
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (raddr)
					`GLCH_OFF_CTRL: s_axi_rdata <= {31'h0, ack_en_r};
					`GLCH_OFF_CMD:  s_axi_rdata <= {20'h0, len_r, 5'h0, op_r};
					`GLCH_OFF_ARG0: s_axi_rdata <= args_r[31:0];
					`GLCH_OFF_ARG1: s_axi_rdata <= args_r[63:32];
					`GLCH_OFF_ARG2: s_axi_rdata <= args_r[95:64];
					`GLCH_OFF_RESP: s_axi_rdata <= {14'h0, resp_r};
					`GLCH_OFF_STAT: s_axi_rdata <= {30'h0, stat_r};
					`GLCH_OFF_MASK: s_axi_rdata <= {30'h0, mask_r};
					`GLCH_OFF_PINS: s_axi_rdata <= {in_sync_r, lvl_r};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// a set in the clearing cycle survives the read
			stat_r <= (stat_rd ? 2'b00 : stat_r) |
				{go_r & send & (n_code != `GLCH_RC_OK), go_r};
			if (go_r) begin
				mode_r    <= n_mode;
				lvl_r     <= n_lvl;
				led_pin_r <= n_led_pin;
				led_inv_r <= n_led_inv;
				if (send)
					resp_r <= {n_hasfld, 1'b1, n_fld, n_code};
				else
					resp_r <= 18'h0;
			end
		end
	end

	assign irq = |(stat_r & mask_r);

	// pins and indicators
	always @(posedge aclk) begin
		if (!aresetn) begin
			in_meta_r <= 16'h0;
			in_sync_r <= 16'h0;
		end else begin
			in_meta_r <= pin_in;
			in_sync_r <= in_meta_r;
		end
	end

	wire [4:0] led_act;
	wire [3:0] evt = {ser_tx_evt, ser_rx_evt, net_tx_evt, net_rx_evt};
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_pulse
			glch_pulse #(
				.CYC     (LED_PULSE_CYC)
			) u_pulse (
				.aclk    (aclk),
				.aresetn (aresetn),
				.trig    (evt[g]),
				.active  (led_act[g])
			);
		end
	endgenerate
	assign led_act[4] = awake;

	reg [15:0] drv_lvl;
	reg [15:0] drv_en;
	reg [3:0]  li;
	integer    k;
	integer    q;
	always @* begin
		drv_lvl = lvl_r;
		drv_en  = 16'h0;
		li      = 4'h0;
		for (k = 0; k < 16; k = k + 1)
			drv_en[k] = (mode_r[2*k +: 2] == `GLCH_MODE_GOUT) ||
				(mode_r[2*k +: 2] == `GLCH_MODE_LED);
		for (q = 0; q < NLED; q = q + 1) begin
			li = led_pin_r[8*q +: 4] - 4'h1;
			if (led_pin_r[8*q +: 8] != 8'h00)
				drv_lvl[li] = led_act[q] ^ led_inv_r[q];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out  <= 16'h0;
			pin_oe_n <= 16'hffff;
		end else begin
			pin_out  <= drv_lvl;
			pin_oe_n <= ~drv_en;
		end
	end
endmodule // glch_top

`default_nettype wire

// ### sim/glch_props.sv
`default_nettype none
module glch_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [15:0] pin_oe_n,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_after_take_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready))
		else $error("write answer without request");
	aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pending");
	r_after_take_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	r_err_data_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("bad read error answer");
	// pin modes only move as the outcome of a register command
	oe_cause_a: assert property ($changed(pin_oe_n) |-> $past(s_axi_awready, 2) || $past(s_axi_awready, 3) || $past(s_axi_awready, 4))
		else $error("pin mode changed without command");
	// irq rises only after a mask write or a command write
	irq_cause_a: assert property ($rose(irq) |-> $past(s_axi_awready) || $past(s_axi_awready, 2))
		else $error("interrupt without cause");
	wr_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_c: cover property (s_axi_rvalid && s_axi_rready);
	irq_c: cover property ($rose(irq));
endmodule // glch_props
bind glch_top glch_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .pin_oe_n(pin_oe_n), .irq(irq));
`default_nettype wire

// ### sim/glch_pins.sv
`default_nettype none
module glch_pins (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] ext_low,
	output logic      [15:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pins float up on board pull-ups unless something outside holds them low
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ~ext_low);
endmodule // glch_pins
`default_nettype wire

// ### sim/gpio_led_command_handler_test.sv
`include "glch_defs.vh"
`default_nettype none
module gpio_led_command_handler_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] OK = 32'h0001_0000;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awake, ien;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [1:0]  bresp, rresp, lb, lr;
	logic [3:0]  evt, wstrb;
	logic [3:0]  lens [1:5];
	logic [15:0] iface, wake, pin_in, pin_out, oe_n, ext_low;
	int          err_count, samples_checked;

	glch_top #(.LED_PULSE_CYC(20), .GPIO_CAP(16'h7fff), .LED_CAP(16'h7fff)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.net_rx_evt(evt[0]), .net_tx_evt(evt[1]), .ser_rx_evt(evt[2]), .ser_tx_evt(evt[3]),
		.awake(awake), .iface_use(iface), .wake_use(wake), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(oe_n), .irq(irq));
	glch_pins u_pins (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_low(ext_low), .pin_in(pin_in));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// entered and left just after a rising edge; bready and rready stay high throughout
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(negedge aclk); while (awready !== 1'b1);
		chk("wready", 32'h1, {31'h0, wready});
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1);
		lb = bresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		lr = rresp;
		@(posedge aclk);
	endtask

	function automatic logic [31:0] rs(input logic [7:0] c, input logic [7:0] f, input logic p);
		return {14'h0, p, 1'b1, f, c};
	endfunction

	task automatic cmd(input logic [2:0] op, input logic [3:0] ln, input logic [31:0] a0,
		input logic [31:0] e);
		wr(`GLCH_OFF_ARG0, a0);
		wr(`GLCH_OFF_CMD, {20'h0, ln, 5'h0, op});
		repeat (4) @(posedge aclk);
		chk("irq", {31'h0, ien}, {31'h0, irq});
		rd(`GLCH_OFF_STAT, v);
		chk("stat", {30'h0, (e[16] && e[7:0] != 8'h00), 1'b1}, v);
		rd(`GLCH_OFF_RESP, v);
		chk("resp", e, v);
	endtask

	task automatic pins(input logic [15:0] po, input logic [15:0] oe);
		chk("pin_out", {16'h0, po}, {16'h0, pin_out});
		chk("pin_oe_n", {16'h0, oe}, {16'h0, oe_n});
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		stop_test();
	end

	initial begin
		{aresetn, awvalid, wvalid, arvalid, evt, awaddr, araddr, wdata} = '0;
		{bready, rready, awake, ien} = 4'he;
		wstrb = 4'hf;
		iface = 16'h0040;
		wake = 16'h0200;
		ext_low = 16'h0040;
		err_count = 0;
		samples_checked = 0;
		lens = '{4'd10, 4'd2, 4'd2, 4'd1, 4'd1};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`GLCH_OFF_CTRL, v);
		chk("ctrl", 32'h1, v);
		rd(`GLCH_OFF_MASK, v);
		chk("mask", 32'h0, v);
		rd(8'h24, v);
		chk("unmapped rresp", 32'h2, {30'h0, lr});
		wr(8'h28, 32'hffff_ffff);
		chk("unmapped bresp", 32'h2, {30'h0, lb});
		wr(`GLCH_OFF_ARG1, 32'haabb_ccdd);
		wstrb <= 4'h2;
		wr(`GLCH_OFF_ARG1, 32'h1122_3344);
		wr(`GLCH_OFF_CTRL, 32'h0);
		wstrb <= 4'hf;
		rd(`GLCH_OFF_ARG1, v);
		chk("arg1 lanes", 32'haabb_33dd, v);
		rd(`GLCH_OFF_CTRL, v);
		chk("ctrl lane", 32'h1, v);
		wr(`GLCH_OFF_MASK, 32'h1);
		ien = 1'b1;
		cmd(`GLCH_OP_GPIOCFG, 4'd2, 32'h0303, OK);
		rd(`GLCH_OFF_STAT, v);
		chk("stat cleared", 32'h0, v);
		rd(`GLCH_OFF_CMD, v);
		chk("cmd", 32'h0000_0202, v);
		pins(16'h0004, 16'hfffb);
		cmd(`GLCH_OP_GPIOCFG, 4'd2, 32'h0103, rs(8'h09, 8'h03, 1));
		pins(16'h0004, 16'hfffb);
		cmd(`GLCH_OP_GPIOCFG, 4'd2, 32'h0310, rs(8'h08, 8'h10, 1));
		cmd(`GLCH_OP_GPIOCFG, 4'd2, 32'h0300, rs(8'h08, 8'h00, 1));
		cmd(`GLCH_OP_GPIOCFG, 4'd2, 32'h0904, rs(8'h12, 8'h00, 0));
		cmd(`GLCH_OP_WRITE, 4'd2, 32'h0003, OK);
		pins(16'h0000, 16'hfffb);
		cmd(`GLCH_OP_TOGGLE, 4'd1, 32'h0003, OK);
		pins(16'h0004, 16'hfffb);
		rd(`GLCH_OFF_PINS, v);
		chk("pins reg", 32'hffbf_0004, v);
		cmd(`GLCH_OP_WRITE, 4'd2, 32'h0105, rs(8'h16, 8'h05, 1));
		cmd(`GLCH_OP_TOGGLE, 4'd1, 32'h0010, rs(8'h08, 8'h10, 1));
		cmd(`GLCH_OP_READ, 4'd1, 32'h03, rs(8'h00, 8'h01, 1));
		cmd(`GLCH_OP_READ, 4'd1, 32'h06, rs(8'h17, 8'h06, 1));
		cmd(`GLCH_OP_READ, 4'd1, 32'h00, rs(8'h08, 8'h00, 1));
		cmd(`GLCH_OP_READ, 4'd1, 32'h07, rs(8'h00, 8'h00, 1));
		cmd(`GLCH_OP_READ, 4'd1, 32'h0a, rs(8'h00, 8'h01, 1));
		for (int op = 1; op <= 5; op++) begin
			cmd(op[2:0], lens[op] - 4'd1, 32'h0, rs(8'h01, 8'h00, 0));
			cmd(op[2:0], lens[op] + 4'd1, 32'h0, rs(8'h02, 8'h00, 0));
		end
		// unknown opcode: no response, done only
		cmd(3'h6, 4'h1, 32'h0, 32'h0);
		wr(`GLCH_OFF_CTRL, 32'h0);
		wr(`GLCH_OFF_MASK, 32'h0);
		ien = 1'b0;
		cmd(`GLCH_OP_TOGGLE, 4'd1, 32'h0003, 32'h0);
		pins(16'h0000, 16'hfffb);
		wr(`GLCH_OFF_CTRL, 32'h1);
		wr(`GLCH_OFF_MASK, 32'h2);
		ien = 1'b1;
		wr(`GLCH_OFF_ARG1, 32'h0);
		wr(`GLCH_OFF_ARG2, 32'h0309);
		cmd(`GLCH_OP_LEDCFG, 4'd10, 32'h0003_0008, rs(8'h12, 8'h00, 0));
		cmd(`GLCH_OP_LEDCFG, 4'd10, 32'h0103_0508, rs(8'h09, 8'h03, 1));
		cmd(`GLCH_OP_LEDCFG, 4'd10, 32'h0110_0508, rs(8'h08, 8'h10, 1));
		pins(16'h0000, 16'hfffb);
		ien = 1'b0;
		cmd(`GLCH_OP_LEDCFG, 4'd10, 32'h0000_0508, OK);
		// power indicator is inverted: active low while awake
		pins(16'h0000, 16'hfe7b);
		evt <= 4'hf;
		@(posedge aclk);
		evt <= 4'h0;
		repeat (4) @(posedge aclk);
		pins(16'h0080, 16'hfe7b);
		repeat (30) @(posedge aclk);
		pins(16'h0000, 16'hfe7b);
		awake <= 1'b0;
		repeat (4) @(posedge aclk);
		pins(16'h0100, 16'hfe7b);
		cmd(`GLCH_OP_READ, 4'd1, 32'h08, rs(8'h00, 8'h00, 1));
		stop_test();
	end
endmodule // gpio_led_command_handler_test
`default_nettype wire
